// ---- tic_top.sv ----
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`include "tic_cfg.svh"
// two timer/counters with five-source two-level interrupt control
module tic_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // pins
  input  wire logic        ext_irq_pin0_i,
  input  wire logic        ext_irq_pin1_i,
  input  wire logic        cnt_pin0_i,
  input  wire logic        cnt_pin1_i,
  // serial port request levels
  input  wire logic        rx_done_flag_i,
  input  wire logic        tx_done_flag_i,
  // core interrupt handshake
  input  wire logic        irq_ack_i,
  output logic             irq_req_o,
  output logic      [15:0] irq_vector_o
);
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_priority_reg;
  logic [7:0] timer_ctrl_flags;
  logic [7:0] timer_mode_cfg;
  logic [1:0] in_service_reg;  // [1] high level, [0] low level
  logic [3:0] pin_s;
  logic [3:0] pin_d_reg;
  logic [3:0] mcyc_reg;
  logic       mtick;
  logic [1:0] cfall;
  logic [7:0] tl0, th0, tl1, th1;
  logic       ovf0, ovf0h, ovf1, ovf1h;
  logic [`NSRC-1:0] src_req;
  logic [`NSRC-1:0] src_en;
  logic [`NSRC-1:0] hi_req;
  logic [`NSRC-1:0] lo_req;
  logic [2:0]  pick;
  logic        pick_vld;
  logic        pick_hi;
  logic [2:0]  sel_src_reg;
  logic        sel_hi_reg;
  tic_pkg::ack_state_e ack_state_reg;
  logic        wb_hit;
  logic [3:0]  wadr;
  logic        wr_byte;
  logic        tick0_lo, tick0_hi, tick1;
  logic        run0, run1;
  logic [1:0]  ext_low;
  logic        clr_src_vld;

  tic_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({cnt_pin1_i, cnt_pin0_i, ext_irq_pin1_i, ext_irq_pin0_i}),
    .pin_o (pin_s)
  );

  assign wb_hit  = cyc_i && stb_i && !ack_o;
  assign wadr    = adr_i[5:2];
  assign wr_byte = wb_hit && we_i && sel_i[0];

  // machine cycle: one tick per twelve clocks
  // pins sampled once a machine cycle, so a pulse shorter than
  // twelve clocks may be missed by the edge detectors
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcyc_reg  <= 4'h0;
      pin_d_reg <= 4'hF;
    end else begin
      mcyc_reg  <= (mcyc_reg == `MCYC) ? 4'h0 : mcyc_reg + 4'h1;
      if (mcyc_reg == `MCYC) begin
        pin_d_reg <= pin_s;
      end
    end
  end
  assign mtick = (mcyc_reg == `MCYC);
  // count pins sampled once a machine cycle, falls counted
  assign cfall = pin_d_reg[3:2] & ~pin_s[3:2] & {2{mtick}};

  assign run0 = timer_ctrl_flags[`B_TR0] &&
                (!timer_mode_cfg[`B_GATE] || pin_s[0]);
  assign run1 = timer_ctrl_flags[`B_TR1] &&
                (!timer_mode_cfg[4+`B_GATE] || pin_s[1]);
  assign tick0_lo = run0 &&
    (timer_mode_cfg[`B_CT] ? cfall[0] : mtick);
  // in split mode the high byte of timer 0 borrows timer 1 run
  assign tick0_hi = timer_ctrl_flags[`B_TR1] && mtick;
  assign tick1 = run1 &&
    (timer_mode_cfg[4+`B_CT] ? cfall[1] : mtick);

  tic_counter u_tmr0 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mode_i    (timer_mode_cfg[1:0]),
    .tick_lo_i (tick0_lo),
    .tick_hi_i (tick0_hi),
    .hold_i    (1'b0),
    .wr_lo_i   (wr_byte && wadr == `ADR_TL0),
    .wr_hi_i   (wr_byte && wadr == `ADR_TH0),
    .wdata_i   (dat_i[7:0]),
    .lo_o      (tl0),
    .hi_o      (th0),
    .ovf_lo_o  (ovf0),
    .ovf_hi_o  (ovf0h)
  );

  tic_counter u_tmr1 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .mode_i    (timer_mode_cfg[5:4]),
    .tick_lo_i (tick1),
    .tick_hi_i (1'b0),
    .hold_i    (timer_mode_cfg[5:4] == 2'b11),
    .wr_lo_i   (wr_byte && wadr == `ADR_TL1),
    .wr_hi_i   (wr_byte && wadr == `ADR_TH1),
    .wdata_i   (dat_i[7:0]),
    .lo_o      (tl1),
    .hi_o      (th1),
    .ovf_lo_o  (ovf1),
    .ovf_hi_o  (ovf1h)
  );

  // low-level mode: pin level itself requests
  assign ext_low = ~pin_s[1:0];
  assign src_req[0] = timer_ctrl_flags[`B_IT0] ?
    timer_ctrl_flags[`B_IE0] : ext_low[0];
  assign src_req[1] = timer_ctrl_flags[`B_TF0];
  assign src_req[2] = timer_ctrl_flags[`B_IT1] ?
    timer_ctrl_flags[`B_IE1] : ext_low[1];
  assign src_req[3] = timer_ctrl_flags[`B_TF1];
  assign src_req[4] = rx_done_flag_i || tx_done_flag_i;

  genvar g;
  generate
    for (g = 0; g < `NSRC; g = g + 1) begin : g_src
      assign src_en[g] = irq_enable_reg[`B_EA] && irq_enable_reg[g]
                         && src_req[g];
      assign hi_req[g] = src_en[g] && irq_priority_reg[g];
      assign lo_req[g] = src_en[g] && !irq_priority_reg[g];
    end
  endgenerate

  // fixed order inside a level, lowest index first
  // high level scan runs last so it overrides any low level pick
  // low level blocked by either in-service bit, high only by its own
  always_comb begin
    pick     = 3'h0;
    pick_vld = 1'b0;
    pick_hi  = 1'b0;
    for (int i = `NSRC - 1; i >= 0; i--) begin
      if (lo_req[i] && !in_service_reg[1] && !in_service_reg[0]) begin
        pick     = 3'(i);
        pick_vld = 1'b1;
      end
    end
    for (int i = `NSRC - 1; i >= 0; i--) begin
      if (hi_req[i] && !in_service_reg[1]) begin
        pick     = 3'(i);
        pick_vld = 1'b1;
        pick_hi  = 1'b1;
      end
    end
  end

  assign clr_src_vld = (ack_state_reg == tic_pkg::ACK_PEND) && irq_ack_i;

  // request/acknowledge toward the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_state_reg  <= tic_pkg::ACK_IDLE;
      sel_src_reg    <= 3'h0;
      sel_hi_reg     <= 1'b0;
      in_service_reg <= 2'b00;
      irq_req_o      <= 1'b0;
      irq_vector_o   <= 16'h0000;
    end else begin
      case (ack_state_reg)
        tic_pkg::ACK_IDLE: if (pick_vld) begin
          ack_state_reg <= tic_pkg::ACK_PEND;
          sel_src_reg   <= pick;
          sel_hi_reg    <= pick_hi;
          irq_req_o     <= 1'b1;
          case (pick)
            3'h0:    irq_vector_o <= `VEC_X0;
            3'h1:    irq_vector_o <= `VEC_T0;
            3'h2:    irq_vector_o <= `VEC_X1;
            3'h3:    irq_vector_o <= `VEC_T1;
            default: irq_vector_o <= `VEC_SER;
          endcase
        end
        tic_pkg::ACK_PEND: if (irq_ack_i) begin
          ack_state_reg <= tic_pkg::ACK_DONE;
          irq_req_o     <= 1'b0;
          in_service_reg[sel_hi_reg] <= 1'b1;
        end
        tic_pkg::ACK_DONE: ack_state_reg <= tic_pkg::ACK_IDLE;
        default: ack_state_reg <= tic_pkg::ACK_IDLE;
      endcase
      // return from service releases highest active level
      if (wb_hit && we_i && wadr == `ADR_RETI) begin
        if (in_service_reg[1]) begin
          in_service_reg[1] <= 1'b0;
        end else begin
          in_service_reg[0] <= 1'b0;
        end
      end
    end
  end

  // enable, priority and mode registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_reg   <= 8'h00;
      irq_priority_reg <= 8'h00;
      timer_mode_cfg   <= 8'h00;
    end else if (wr_byte) begin
      if (wadr == `ADR_IE) begin
        irq_enable_reg <= dat_i[7:0] & 8'h9F;
      end
      if (wadr == `ADR_IP) begin
        irq_priority_reg <= dat_i[7:0] & 8'h1F;
      end
      if (wadr == `ADR_TIMER_MODE_CFG) begin
        timer_mode_cfg <= dat_i[7:0];
      end
    end
  end

  // control/flags: hardware set beats any clear
  // ordering inside the block gives set the last word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ctrl_flags <= 8'h00;
    end else begin
      if (wr_byte && wadr == `ADR_TIMER_CTRL_FLAGS) begin
        timer_ctrl_flags <= dat_i[7:0];
      end
      if (clr_src_vld) begin
        case (sel_src_reg)
          3'h0: if (timer_ctrl_flags[`B_IT0])
            timer_ctrl_flags[`B_IE0] <= 1'b0;
          3'h1: timer_ctrl_flags[`B_TF0] <= 1'b0;
          3'h2: if (timer_ctrl_flags[`B_IT1])
            timer_ctrl_flags[`B_IE1] <= 1'b0;
          3'h3: timer_ctrl_flags[`B_TF1] <= 1'b0;
          default: ;
        endcase
      end
      if (pin_d_reg[0] && !pin_s[0] && mtick) begin
        timer_ctrl_flags[`B_IE0] <= 1'b1;
      end
      if (pin_d_reg[1] && !pin_s[1] && mtick) begin
        timer_ctrl_flags[`B_IE1] <= 1'b1;
      end
      if (ovf0) begin
        timer_ctrl_flags[`B_TF0] <= 1'b1;
      end
      // split mode: timer 0 high byte owns the timer 1 flag
      if (timer_mode_cfg[1:0] == 2'b11 ? ovf0h : ovf1) begin
        timer_ctrl_flags[`B_TF1] <= 1'b1;
      end
    end
  end

  // wishbone answer one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_hit;
      dat_o <= 32'h0000_0000;
      if (wb_hit && !we_i) begin
        case (wadr)
          `ADR_IE:     dat_o[7:0] <= irq_enable_reg;
          `ADR_IP:     dat_o[7:0] <= irq_priority_reg;
          `ADR_TIMER_CTRL_FLAGS:   dat_o[7:0] <= timer_ctrl_flags;
          `ADR_TIMER_MODE_CFG:   dat_o[7:0] <= timer_mode_cfg;
          `ADR_TL0:    dat_o[7:0] <= tl0;
          `ADR_TH0:    dat_o[7:0] <= th0;
          `ADR_TL1:    dat_o[7:0] <= tl1;
          `ADR_TH1:    dat_o[7:0] <= th1;
          // bit 5 is the timer 0 high-byte overflow pulse of split mode
          `ADR_STAT:   dat_o[5:0] <= {ovf0h, sel_hi_reg, in_service_reg,
                                      irq_req_o, pick_vld};
          `ADR_SERIAL: dat_o[1:0] <= {tx_done_flag_i, rx_done_flag_i};
          default:     dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- tic_cfg.svh ----
// Functional notes
// - master enable off blocks every interrupt
// - enable register holds five per-source bits
// - each source vectors to fixed address
// - trigger type selects low level or falling edge
// - edge flag set on detect, cleared on service
// - priority register gives each source level bit
// - only higher level may preempt active service
// - same level resolved in fixed source order
// - overflow flag set, cleared on vectoring
// - run bits turn each timer on/off
// - gating counts only while irq pin high
// - source select picks clock or count pin
// - mode bits pick 13/16/8-reload/split modes
// - mode 3 splits timer 0 into two bytes
// - timer 1 in mode 3 holds value
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH
`define ADR_IE      4'h0
`define ADR_IP      4'h1
`define ADR_TIMER_CTRL_FLAGS    4'h2
`define ADR_TIMER_MODE_CFG    4'h3
`define ADR_TL0     4'h4
`define ADR_TH0     4'h5
`define ADR_TL1     4'h6
`define ADR_TH1     4'h7
`define ADR_STAT    4'h8
`define ADR_RETI    4'h9
`define ADR_SERIAL  4'hA
`define B_EA        7
`define B_TF1       7
`define B_TR1       6
`define B_TF0       5
`define B_TR0       4
`define B_IE1       3
`define B_IT1       2
`define B_IE0       1
`define B_IT0       0
`define B_GATE      3
`define B_CT        2
`define NSRC        5
`define MCYC        4'hB
`define PRE_TOP     5'h1F
`define VEC_X0      16'h0003
`define VEC_T0      16'h000B
`define VEC_X1      16'h0013
`define VEC_T1      16'h001B
`define VEC_SER     16'h0023
`endif

// ---- tic_pkg.sv ----
package tic_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } tmr_mode_e;
  typedef enum logic [1:0] {
    ACK_IDLE,
    ACK_PEND,
    ACK_DONE
  } ack_state_e;
endpackage

// ---- tic_sync.sv ----
`timescale 1ns/1ns
// two-stage synchroniser for pin inputs
module tic_sync (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // pins
  input  wire logic [3:0] pin_i,
  output logic      [3:0] pin_o
);
  logic [3:0] meta_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 4'hF;
      pin_o    <= 4'hF;
    end else begin
      meta_reg <= pin_i;
      pin_o    <= meta_reg;
    end
  end
endmodule

// ---- tic_counter.sv ----
`timescale 1ns/1ns
`include "tic_cfg.svh"
// one timer/counter: low and high byte, four modes
module tic_counter (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic [1:0] mode_i,
  input  wire logic       tick_lo_i,
  input  wire logic       tick_hi_i,
  input  wire logic       hold_i,
  // software writes
  input  wire logic       wr_lo_i,
  input  wire logic       wr_hi_i,
  input  wire logic [7:0] wdata_i,
  // state
  output logic      [7:0] lo_o,
  output logic      [7:0] hi_o,
  output logic            ovf_lo_o,
  output logic            ovf_hi_o
);
  logic [8:0] lo_sum;
  logic [8:0] hi_sum;
  logic [4:0] pre;
  logic       pre_carry;
  assign lo_sum    = {1'b0, lo_o} + 9'h001;
  assign hi_sum    = {1'b0, hi_o} + 9'h001;
  assign pre       = lo_o[4:0];
  assign pre_carry = (pre == `PRE_TOP);

  always_ff @(posedge clk_i) begin
    ovf_lo_o <= 1'b0;
    ovf_hi_o <= 1'b0;
    if (rst_i) begin
      lo_o <= 8'h00;
      hi_o <= 8'h00;
    end else if (wr_lo_i) begin
      lo_o <= wdata_i;
    end else if (wr_hi_i) begin
      hi_o <= wdata_i;
    end else if (!hold_i) begin
      case (tic_pkg::tmr_mode_e'(mode_i))
        tic_pkg::MODE_13BIT: if (tick_lo_i) begin
          lo_o[4:0] <= pre + 5'h01;
          if (pre_carry) begin
            hi_o     <= hi_sum[7:0];
            ovf_lo_o <= hi_sum[8];
          end
        end
        tic_pkg::MODE_16BIT: if (tick_lo_i) begin
          lo_o <= lo_sum[7:0];
          if (lo_sum[8]) begin
            hi_o     <= hi_sum[7:0];
            ovf_lo_o <= hi_sum[8];
          end
        end
        tic_pkg::MODE_RELOAD: if (tick_lo_i) begin
          lo_o     <= lo_sum[8] ? hi_o : lo_sum[7:0];
          ovf_lo_o <= lo_sum[8];
        end
        tic_pkg::MODE_SPLIT: begin
          if (tick_lo_i) begin
            lo_o     <= lo_sum[7:0];
            ovf_lo_o <= lo_sum[8];
          end
          if (tick_hi_i) begin
            hi_o     <= hi_sum[7:0];
            ovf_hi_o <= hi_sum[8];
          end
        end
        default: lo_o <= lo_o;
      endcase
    end
  end
endmodule

// ---- tic_checker.sv ----
`timescale 1ns/1ns
module tic_checker (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        ack_o,
  input  wire logic [31:0] dat_o,
  // interrupt handshake
  input  wire logic        irq_ack_i,
  input  wire logic        irq_req_o,
  input  wire logic [15:0] irq_vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // one done cycle and one idle cycle before any new request
  sequence s_done;
    !irq_req_o [*2];
  endsequence
  sequence s_take;
    irq_req_o && irq_ack_i;
  endsequence
  property p_ack_next;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_ack_quiet;
    !cyc_i |=> !ack_o;
  endproperty
  property p_dat_idle;
    !ack_o |-> dat_o == 32'h0000_0000;
  endproperty
  property p_req_hold;
    irq_req_o && !irq_ack_i |=> irq_req_o && $stable(irq_vector_o);
  endproperty
  property p_req_end;
    s_take |=> s_done;
  endproperty
  property p_vec_set;
    irq_req_o |-> irq_vector_o inside {16'h0003, 16'h000B, 16'h0013,
                                       16'h001B, 16'h0023};
  endproperty
  property p_reset_clr;
    $fell(rst_i) |-> !ack_o && !irq_req_o && irq_vector_o == 16'h0000;
  endproperty
  a_ack_next:  assert property (p_ack_next) else $error("ack late");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_ack_quiet: assert property (p_ack_quiet) else $error("ack unasked");
  a_dat_idle:  assert property (p_dat_idle) else $error("dat_o not zero");
  a_req_hold:  assert property (p_req_hold) else $error("req not held");
  a_req_end:   assert property (p_req_end) else $error("req after ack");
  a_vec_set:   assert property (p_vec_set) else $error("bad vector");
  a_reset_clr: assert property (p_reset_clr) else $error("reset state");
endmodule

bind tic_top tic_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
  .dat_o, .irq_ack_i, .irq_req_o, .irq_vector_o);

// ---- tic_core_model.sv ----
`timescale 1ns/1ns
// core side: takes each vector after a programmable wait
module tic_core_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // handshake
  input  wire logic        req_i,
  input  wire logic [15:0] vec_i,
  input  wire logic [3:0]  delay_i,
  output logic             ack_o,
  output logic      [15:0] last_vec_o,
  output logic      [7:0]  n_acks_o
);
  logic [3:0] wait_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o      <= 1'b0;
      wait_reg   <= 4'h0;
      last_vec_o <= 16'h0000;
      n_acks_o   <= 8'h00;
    end else if (ack_o) begin
      ack_o    <= 1'b0;
      wait_reg <= 4'h0;
    end else if (req_i && wait_reg == delay_i) begin
      ack_o      <= 1'b1;
      last_vec_o <= vec_i;
      n_acks_o   <= n_acks_o + 8'h01;
    end else if (req_i) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// ---- timer_interrupt_control_tb.sv ----
`timescale 1ns/1ns
module timer_interrupt_control_tb;
  logic        clk_i, rst_i, cyc, stb, we, ack, pin0, pin1, cnt0, cnt1;
  logic        rx, tx, irq_ack, irq_req;
  logic [5:0]  adr;
  logic [3:0]  sel, delay;
  logic [31:0] wdat, rdat;
  logic [15:0] vec, last_vec;
  logic [7:0]  n_acks, rd_q;
  int          fail_count, n_tests;
  tic_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .ext_irq_pin0_i(pin0), .ext_irq_pin1_i(pin1),
    .cnt_pin0_i(cnt0), .cnt_pin1_i(cnt1), .rx_done_flag_i(rx),
    .tx_done_flag_i(tx), .irq_ack_i(irq_ack), .irq_req_o(irq_req),
    .irq_vector_o(vec));
  tic_core_model core (.clk_i(clk_i), .rst_i(rst_i), .req_i(irq_req),
    .vec_i(vec), .delay_i(delay), .ack_o(irq_ack), .last_vec_o(last_vec),
    .n_acks_o(n_acks));
  always #20 clk_i = ~clk_i;
  task finish_test;
    $display("tests %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string nm, input logic [15:0] seen, input logic [15:0] e);
    n_tests++;
    if (seen !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {a, 2'b00};
    wdat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1)
      fail_count++;
    rd_q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(nm, {8'h00, rd_q}, {8'h00, e});
  endtask
  // poll a bit of a register until hardware sets it
  task poll(input logic [3:0] a, input int b);
    int k;
    k = 0;
    do begin
      xfer(1'b0, a, 8'h00);
      k++;
    end while (rd_q[b] !== 1'b1 && k < 100);
    check("poll", {15'h0000, rd_q[b]}, 16'h0001);
  endtask
  task wait_vec(input string nm, input logic [15:0] e);
    int k;
    logic [7:0] n0;
    n0 = n_acks;
    k = 0;
    while (n_acks === n0 && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    check(nm, last_vec, e);
  endtask
  task t_reset;
    for (int w = 0; w < 8; w++)
      rd_chk("reset", w[3:0], 8'h00);
  endtask
  task t_regs;
    wr(4'h0, 8'hFF);
    rd_chk("ie", 4'h0, 8'h9F);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'hFF);
    rd_chk("ip", 4'h1, 8'h1F);
    wr(4'h1, 8'h00);
    rd_chk("unmapped", 4'hF, 8'h00);
  endtask
  task t_ovf;
    wr(4'h3, 8'h01);
    wr(4'h5, 8'hFF);
    wr(4'h4, 8'hFE);
    wr(4'h2, 8'h10);
    poll(4'h2, 5);
    wr(4'h2, 8'h20);
    check("masked", {15'h0000, irq_req}, 16'h0000);
    rd_chk("tf0", 4'h2, 8'h20);
    rd_chk("tl0", 4'h4, 8'h00);
    rd_chk("th0", 4'h5, 8'h00);
    wr(4'h0, 8'h82);
    wait_vec("vec t0", 16'h000B);
    rd_chk("tf0 clr", 4'h2, 8'h00);
    wr(4'h9, 8'h00);
  endtask
  task t_reload;
    wr(4'h0, 8'h00);
    wr(4'h3, 8'h02);
    wr(4'h5, 8'hF0);
    wr(4'h4, 8'hFE);
    wr(4'h2, 8'h10);
    poll(4'h2, 5);
    wr(4'h2, 8'h00);
    rd_chk("reload", 4'h4, 8'hF0);
    rd_chk("th0 kept", 4'h5, 8'hF0);
  endtask
  task t_split;
    wr(4'h3, 8'h33);
    wr(4'h5, 8'hFF);
    wr(4'h4, 8'h00);
    wr(4'h2, 8'h40);
    poll(4'h2, 7);
    wr(4'h2, 8'h00);
    rd_chk("split tl0", 4'h4, 8'h00);
    rd_chk("split th0", 4'h5, 8'h00);
  endtask
  task t_13bit;
    wr(4'h3, 8'h00);
    wr(4'h5, 8'hFF);
    wr(4'h4, 8'hFE);
    wr(4'h2, 8'h10);
    poll(4'h2, 5);
    wr(4'h2, 8'h00);
    rd_chk("13bit tl0", 4'h4, 8'hE0);
    rd_chk("13bit th0", 4'h5, 8'h00);
  endtask
  task t_order;
    wr(4'h2, 8'h05);
    pin0 <= 1'b0;
    pin1 <= 1'b0;
    repeat (40) @(posedge clk_i);
    pin0 <= 1'b1;
    pin1 <= 1'b1;
    rd_chk("edges", 4'h2, 8'h0F);
    wr(4'h0, 8'h85);
    wait_vec("first", 16'h0003);
    rd_chk("ie0 clr", 4'h2, 8'h0D);
    repeat (30) @(posedge clk_i);
    check("no preempt", {15'h0000, irq_req}, 16'h0000);
    wr(4'h9, 8'h00);
    wait_vec("second", 16'h0013);
    wr(4'h9, 8'h00);
  endtask
  task t_nest;
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h04);
    delay <= 4'h3;
    pin0  <= 1'b0;
    repeat (40) @(posedge clk_i);
    pin0 <= 1'b1;
    wr(4'h0, 8'h85);
    wait_vec("low", 16'h0003);
    pin1 <= 1'b0;
    repeat (40) @(posedge clk_i);
    pin1 <= 1'b1;
    wait_vec("nested", 16'h0013);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h00);
    wr(4'h1, 8'h00);
  endtask
  task t_level_serial;
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h81);
    pin0 <= 1'b0;
    wait_vec("level", 16'h0003);
    pin0 <= 1'b1;
    wr(4'h9, 8'h00);
    wr(4'h0, 8'h90);
    rx <= 1'b1;
    wait_vec("serial", 16'h0023);
    rx <= 1'b0;
    wr(4'h9, 8'h00);
    wr(4'h0, 8'h00);
  endtask
  task t_count;
    wr(4'h3, 8'h05);
    wr(4'h4, 8'h00);
    wr(4'h2, 8'h10);
    repeat (3) begin
      repeat (30) @(posedge clk_i);
      cnt0 <= 1'b0;
      repeat (30) @(posedge clk_i);
      cnt0 <= 1'b1;
    end
    repeat (30) @(posedge clk_i);
    wr(4'h2, 8'h00);
    rd_chk("events", 4'h4, 8'h03);
    wr(4'h3, 8'h09);
    wr(4'h4, 8'h00);
    pin0 <= 1'b0;
    wr(4'h2, 8'h10);
    repeat (60) @(posedge clk_i);
    wr(4'h2, 8'h00);
    pin0 <= 1'b1;
    rd_chk("gated", 4'h4, 8'h00);
    wr(4'h3, 8'h30);
    wr(4'h2, 8'h40);
    repeat (60) @(posedge clk_i);
    rd_chk("t1 held", 4'h6, 8'h00);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we, rx, tx} = 5'b00000;
    {pin0, pin1, cnt0, cnt1} = 4'hF;
    adr   = 6'h00;
    sel   = 4'h1;
    wdat  = 32'h0000_0000;
    delay = 4'h0;
    fail_count = 0;
    n_tests    = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_ovf();
    t_reload();
    t_split();
    t_13bit();
    t_order();
    t_nest();
    t_level_serial();
    t_count();
    finish_test();
  end
endmodule
